// [logic/vds_cfg.svh]
// register offsets, field positions and reset values for the status bank
`ifndef VDS_CFG_SVH
`define VDS_CFG_SVH
`define VDS_OFS_STATUS1 8'h10
`define VDS_OFS_IDENT 8'h11
`define VDS_OFS_STATUS2 8'h12
`define VDS_OFS_STATUS3 8'h13
`define VDS_OFS_CLAMP 8'h14
`define VDS_S1_LOCK 0
`define VDS_S1_LOST 1
`define VDS_S1_FSC 2
`define VDS_S1_PEAK 3
`define VDS_S1_STD_LO 4
`define VDS_S1_STD_HI 6
`define VDS_S1_KILL 7
`define VDS_S2_STRIPE 0
`define VDS_S2_TYPE3 1
`define VDS_S2_PSYNC 2
`define VDS_S2_AGC 3
`define VDS_S2_LINE 4
`define VDS_S2_FSC 5
`define VDS_S2_RSV_LO 6
`define VDS_S2_RSV_HI 7
`define VDS_S3_UNUSED 0
`define VDS_S3_RSV_LO 2
`define VDS_S3_RSV_HI 4
`define VDS_RDATA_RST 8'h00
`define VDS_RDATA_NONE 8'h00
`define VDS_S3_HLOCK 1
`define VDS_S3_FREERUN 5
`define VDS_S3_FIELDSTD 6
`define VDS_S3_SWING 7
`define VDS_CLAMP_CLAMP_CURRENT_SOURCE_ENABLE 4
`define VDS_CLAMP_RST 8'h12
`define VDS_IDENT_VAL 8'h5A
`endif

// [logic/vds_pkg.sv]
// types shared by the status register bank
package vds_pkg;
  typedef enum logic [2:0] {
    VDS_NTSC_MJ, VDS_NTSC_443, VDS_PAL_M, VDS_PAL_60,
    VDS_PAL_BGHID, VDS_SECAM, VDS_PAL_CN, VDS_SECAM_525
  } vds_std_e;
  typedef logic [7:0] vds_byte_t;
endpackage

// [logic/vds_lost_lock.sv]
// sticky lost-lock flag, cleared by a read of the first status register
`timescale 1ns/10ps
`include "vds_cfg.svh"
module vds_lost_lock (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_lock,
  input wire logic clear,
  output logic lost
);
  logic lost_reg;
  logic lost_next;
  logic lock_d_reg;
  logic lock_d_next;
  always_comb begin
    lock_d_next = in_lock;
    lost_next = lost_reg;
    if (clear) begin
      lost_next = 1'h0;
    end
    // a drop in the clearing cycle still sets the flag
    if (lock_d_reg && !in_lock) begin
      lost_next = 1'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lost_reg <= 1'h0;
      lock_d_reg <= 1'h0;
    end else begin
      lost_reg <= lost_next;
      lock_d_reg <= lock_d_next;
    end
  end
  assign lost = lost_reg;
  lost_sets_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(in_lock) |=> lost) else $error("lost lock not flagged");
endmodule

// [logic/vds_status_regs.sv]
// status, identification and analog clamp registers of the video decoder
// Operation
// - first status bit 3 is high while peak-white gain control is active.
// - first status bits 6:4 report the autodetected television standard.
// - first status bit 7 is high while colour kill is active.
// - offset 0x11 returns a fixed revision code; writes do nothing.
// - second status bit 0 flags colour-striping copy protection.
// - second status bit 1 gives striping type, 0 type 2, 1 type 3.
// - second status bit 2 flags copy-protection pseudo-sync pulses.
// - second status bit 3 flags copy-protection gain-control pulses.
// - bit 4 nonstandard line length, bit 5 nonstandard subcarrier; 7:6 zero.
// - third status: h-lock bit 1, free run 5, field std 6, swing 7.
// - clamp control bit 4 low turns clamp current sources off.
// - first status bit 0 is lock now, bit 2 subcarrier lock now.
// - first status bit 1 records lock lost since last read.
`timescale 1ns/10ps
`include "vds_cfg.svh"
module vds_status_regs #(
  parameter logic [7:0] IDENT_CODE = `VDS_IDENT_VAL // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic in_lock,
  input wire logic fsc_lock,
  input wire logic peak_white_active,
  input wire vds_pkg::vds_std_e detected_std,
  input wire logic color_kill_active,
  input wire logic copy_protection_stripe,
  input wire logic copy_protection_stripe_type3,
  input wire logic copy_protection_pseudo_sync,
  input wire logic copy_protection_agc_pulses,
  input wire logic nonstd_line_length,
  input wire logic nonstd_fsc,
  input wire logic hlock_unfiltered,
  input wire logic free_run_active,
  input wire logic field_length_std,
  input wire logic swinging_burst,
  output logic clamp_current_source_enable
);
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'h0;
      rst_s2_reg <= 1'h0;
    end else begin
      rst_s1_reg <= 1'h1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic lost_lock;
  vds_lost_lock u_lost (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_lock(in_lock),
    .clear(reg_rd && hit(reg_addr, `VDS_OFS_STATUS1)),
    .lost(lost_lock)
  );

  vds_pkg::vds_byte_t status1;
  vds_pkg::vds_byte_t status2;
  vds_pkg::vds_byte_t status3;
  always_comb begin
    status1 = 8'h00;
    status1[`VDS_S1_LOCK] = in_lock;
    status1[`VDS_S1_LOST] = lost_lock;
    status1[`VDS_S1_FSC] = fsc_lock;
    status1[`VDS_S1_PEAK] = peak_white_active;
    status1[`VDS_S1_STD_HI:`VDS_S1_STD_LO] = detected_std;
    status1[`VDS_S1_KILL] = color_kill_active;
    // reserved 7:6 stay zero
    status2 = {2'h0, nonstd_fsc, nonstd_line_length,
      copy_protection_agc_pulses, copy_protection_pseudo_sync,
      copy_protection_stripe_type3, copy_protection_stripe};
    status3 = 8'h00;
    status3[`VDS_S3_HLOCK] = hlock_unfiltered;
    status3[`VDS_S3_FREERUN] = free_run_active;
    status3[`VDS_S3_FIELDSTD] = field_length_std;
    status3[`VDS_S3_SWING] = swinging_burst;
  end

  logic [7:0] clamp_reg;
  logic [7:0] clamp_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  always_comb begin
    clamp_next = clamp_reg;
    // only the clamp register takes writes; status and id ignore them
    if (reg_wr && hit(reg_addr, `VDS_OFS_CLAMP)) begin
      clamp_next = reg_wdata;
    end
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (hit(reg_addr, `VDS_OFS_STATUS1)) begin
        rdata_next = status1;
      end else if (hit(reg_addr, `VDS_OFS_IDENT)) begin
        rdata_next = IDENT_CODE;
      end else if (hit(reg_addr, `VDS_OFS_STATUS2)) begin
        rdata_next = status2;
      end else if (hit(reg_addr, `VDS_OFS_STATUS3)) begin
        rdata_next = status3;
      end else if (hit(reg_addr, `VDS_OFS_CLAMP)) begin
        rdata_next = clamp_reg;
      end else begin
        rdata_next = `VDS_RDATA_NONE;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clamp_reg <= `VDS_CLAMP_RST;
      rdata_reg <= `VDS_RDATA_RST;
    end else begin
      clamp_reg <= clamp_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;
  // clamp sources follow the stored enable bit directly
  assign clamp_current_source_enable = clamp_reg[`VDS_CLAMP_CLAMP_CURRENT_SOURCE_ENABLE];

  // read checks: the byte shows one cycle after the read strobe, so the
  // expected inputs are the ones that stood at the strobe edge
  ident_read_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_IDENT |=> reg_rdata == IDENT_CODE)
    else $error("ident value wrong");
  std_field_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS1
    |=> reg_rdata[`VDS_S1_STD_HI:`VDS_S1_STD_LO] == $past(detected_std))
    else $error("standard field wrong");
  color_kill_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS1
    |=> reg_rdata[`VDS_S1_KILL] == $past(color_kill_active))
    else $error("kill bit wrong");
  peak_white_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS1
    |=> reg_rdata[`VDS_S1_PEAK] == $past(peak_white_active))
    else $error("peak bit wrong");
  lock_bits_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS1
    |=> reg_rdata[`VDS_S1_LOCK] == $past(in_lock)
    && reg_rdata[`VDS_S1_FSC] == $past(fsc_lock))
    else $error("lock bits wrong");
  lost_read_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS1
    |=> reg_rdata[`VDS_S1_LOST] == $past(lost_lock))
    else $error("lost bit not reported");
  // a read with no drop in the same cycle leaves the flag clear
  lost_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS1 && !$fell(in_lock)
    |=> !lost_lock)
    else $error("lost flag not cleared by read");
  stripe_seen_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS2
    |=> reg_rdata[`VDS_S2_STRIPE] == $past(copy_protection_stripe))
    else $error("stripe bit wrong");
  stripe_type_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS2
    |=> reg_rdata[`VDS_S2_TYPE3] == $past(copy_protection_stripe_type3))
    else $error("stripe type bit wrong");
  pseudo_sync_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS2
    |=> reg_rdata[`VDS_S2_PSYNC] == $past(copy_protection_pseudo_sync))
    else $error("pseudo sync bit wrong");
  agc_pulse_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS2
    |=> reg_rdata[`VDS_S2_AGC] == $past(copy_protection_agc_pulses))
    else $error("gain pulse bit wrong");
  nonstd_bits_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS2
    |=> reg_rdata[`VDS_S2_LINE] == $past(nonstd_line_length)
    && reg_rdata[`VDS_S2_FSC] == $past(nonstd_fsc)
    && reg_rdata[`VDS_S2_RSV_HI:`VDS_S2_RSV_LO] == 2'h0)
    else $error("nonstandard bits wrong");
  run_byte_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `VDS_OFS_STATUS3
    |=> reg_rdata[`VDS_S3_RSV_HI:`VDS_S3_RSV_LO] == 3'h0
    && reg_rdata[`VDS_S3_UNUSED] == 1'h0
    && reg_rdata[`VDS_S3_SWING] == $past(swinging_burst)
    && reg_rdata[`VDS_S3_FIELDSTD] == $past(field_length_std)
    && reg_rdata[`VDS_S3_FREERUN] == $past(free_run_active)
    && reg_rdata[`VDS_S3_HLOCK] == $past(hlock_unfiltered))
    else $error("third status wrong");
  unmapped_read_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && (reg_addr < `VDS_OFS_STATUS1 || reg_addr > `VDS_OFS_CLAMP)
    |=> reg_rdata == `VDS_RDATA_NONE)
    else $error("unmapped read not zero");
  // the match ends two cycles after the write, hence a depth of two
  clamp_wr_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == `VDS_OFS_CLAMP ##1 !reg_wr [*2]
    |-> clamp_current_source_enable
    == $past(reg_wdata[`VDS_CLAMP_CLAMP_CURRENT_SOURCE_ENABLE], 2))
    else $error("clamp enable not stored");
  clamp_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == `VDS_OFS_CLAMP)
    |=> $stable(clamp_current_source_enable))
    else $error("clamp enable moved without write");
  ro_write_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr != `VDS_OFS_CLAMP |=> $stable(clamp_reg))
    else $error("write leaked into clamp");
endmodule

// [verif/vds_host_model.sv]
// host side model driving the register access strobes
`timescale 1ns/10ps
module vds_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = (a == 8'h14) ? {3'h0, d[4], 4'h2} : d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // stale data is inverted so a late sample cannot pass by luck
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// [verif/vds_status_regs_tb.sv]
// self-checking bench for the status register bank
`timescale 1ns/10ps
`include "vds_cfg.svh"
module vds_status_regs_tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [13:0] sv = 14'h0001;
  logic [2:0] std_v = 3'h0;
  logic [7:0] addr, wdata, rdata, got;
  logic wr, rd, clamp_en;
  int bad_count = 0;
  int n_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  vds_host_model i_vds_host_model (.clk(ref_clk), .reg_rdata(rdata),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata));
  vds_status_regs i_vds_status_regs (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
    .reg_rdata(rdata), .in_lock(sv[0]), .fsc_lock(sv[1]),
    .peak_white_active(sv[2]), .detected_std(vds_pkg::vds_std_e'(std_v)),
    .color_kill_active(sv[3]), .copy_protection_stripe(sv[4]),
    .copy_protection_stripe_type3(sv[5]),
    .copy_protection_pseudo_sync(sv[6]),
    .copy_protection_agc_pulses(sv[7]), .nonstd_line_length(sv[8]),
    .nonstd_fsc(sv[9]), .hlock_unfiltered(sv[10]),
    .free_run_active(sv[11]), .field_length_std(sv[12]),
    .swinging_burst(sv[13]), .clamp_current_source_enable(clamp_en));
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
    input logic [7:0] e);
    i_vds_host_model.rd(a, got);
    chk(nm, e, got);
  endtask
  function automatic logic [7:0] s1(input logic lost);
    return {sv[3], std_v, sv[2], sv[1], lost, sv[0]};
  endfunction
  task automatic tally_and_finish();
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #75000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("clamp_rst", 8'h01, {7'h0, clamp_en});
    rdchk("clamp", 8'h14, 8'h12);
    i_vds_host_model.wr(8'h14, 8'h00);
    chk("clamp_off", 8'h00, {7'h0, clamp_en});
    rdchk("clamp", 8'h14, 8'h02);
    i_vds_host_model.wr(8'h14, 8'h10);
    chk("clamp_on", 8'h01, {7'h0, clamp_en});
    for (int i = 0; i < 8; i++) begin
      std_v = i[2:0];
      sv[3:0] = {i[0], i[1], ~i[0], 1'b1};
      rdchk("st1", 8'h10, s1(1'b0));
    end
    sv[0] = 1'b0;
    repeat (2) @(negedge ref_clk);
    sv[0] = 1'b1;
    rdchk("lost", 8'h10, s1(1'b1));
    rdchk("lost_clr", 8'h10, s1(1'b0));
    for (int i = 0; i < 11; i++) begin
      sv[13:4] = (i == 10) ? 10'h3FF : 10'h001 << i;
      rdchk("st2", 8'h12, {2'h0, sv[9:4]});
      rdchk("st3", 8'h13, {sv[13:11], 3'h0, sv[10], 1'b0});
    end
    rdchk("ident", 8'h11, `VDS_IDENT_VAL);
    for (int i = 16; i < 20; i++) begin
      i_vds_host_model.wr(i[7:0], 8'hFF);
    end
    rdchk("ident_wr", 8'h11, `VDS_IDENT_VAL);
    rdchk("st2_wr", 8'h12, {2'h0, sv[9:4]});
    rdchk("st1_wr", 8'h10, s1(1'b0));
    rdchk("unmapped", 8'h20, 8'h00);
    chk("clamp_hold", 8'h01, {7'h0, clamp_en});
    tally_and_finish();
  end
endmodule
